/* hw/gpx_pkg.sv */
// Shared constants and types of the I2C GPIO expander
package gpx_pkg;
  // ****************************************
  // Command pointer codes
  // ****************************************
  localparam logic [2:0] PTR_IN0 = 3'h0;
  localparam logic [2:0] PTR_IN1 = 3'h1;
  localparam logic [2:0] PTR_OUT0 = 3'h2;
  localparam logic [2:0] PTR_OUT1 = 3'h3;
  localparam logic [2:0] PTR_POL0 = 3'h4;
  localparam logic [2:0] PTR_POL1 = 3'h5;
  localparam logic [2:0] PTR_CFG0 = 3'h6;
  localparam logic [2:0] PTR_CFG1 = 3'h7;
  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [15:0] OUT_RST = 16'hffff;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hffff;
  localparam logic [15:0] IN_RST = 16'hffff;
  localparam logic [15:0] PIN_SYNC_RST = 16'hffff;
  localparam logic [2:0] ADDR_SYNC_RST = 3'h0;
  // ****************************************
  // Bit counts and address
  // ****************************************
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_RD_BIT = 4'h7;
  // Arbitrary upper address pattern
  localparam logic [3:0] ADDR_HIGH_DEF = 4'h5;
  // ****************************************
  // Bus slave states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
  } i2c_st_e;
endpackage

/* hw/pin_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;

  // Change taken once stages two and three agree
  always_comb begin
    q_d = (s2_q & s3_q) | (q_q & (s2_q | s3_q));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_q <= RST;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end

  assign q = q_q;
endmodule

/* hw/i2c_gpio_expander_16bit.sv */
// I2C slave GPIO expander with two 8-bit ports and change interrupt
`timescale 1ns/1ps
module i2c_gpio_expander_16bit import gpx_pkg::*; #(
  parameter logic [3:0] ADDR_HIGH = ADDR_HIGH_DEF
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDR_SEL_BIT0,
  input wire logic ADDR_SEL_BIT1,
  input wire logic ADDR_SEL_BIT2,
  input wire logic [7:0] PORT_A_IN,
  output logic [7:0] PORT_A_OUT,
  output logic [7:0] PORT_A_OE,
  input wire logic [7:0] PORT_B_IN,
  output logic [7:0] PORT_B_OUT,
  output logic [7:0] PORT_B_OE,
  output logic PULLUP_EN,
  output logic INT_N_OUT,
  output logic INT_N_OE
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  logic [2:0] addr_s;
  logic [15:0] pins_s;

  pin_sync3 #(.W(1), .RST(1'b1)) u_scl (.clk(CLK), .reset(RESET), .d(SCL_IN), .q(scl_s));
  pin_sync3 #(.W(1), .RST(1'b1)) u_sda (.clk(CLK), .reset(RESET), .d(SDA_IN), .q(sda_s));
  pin_sync3 #(.W(3), .RST(ADDR_SYNC_RST)) u_addr (
    .clk(CLK), .reset(RESET), .d({ADDR_SEL_BIT2, ADDR_SEL_BIT1, ADDR_SEL_BIT0}), .q(addr_s)
  );
  pin_sync3 #(.W(16), .RST(PIN_SYNC_RST)) u_pins (
    .clk(CLK), .reset(RESET), .d({PORT_B_IN, PORT_A_IN}), .q(pins_s)
  );

  // ****************************************
  // State
  // ****************************************
  i2c_st_e st_q, st_d, after_q, after_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] ptr_q, ptr_d;
  logic rw_q, rw_d, nack_q, nack_d, oe_q, oe_d, int_q, int_d;
  logic [15:0] out_q, out_d, pol_q, pol_d, cfg_q, cfg_d, in_q, in_d, drv_q, drv_d;
  logic [15:0] live;
  logic start, stop, rise, fall;

  // Polarity applied to sampled level
  assign live = pins_s ^ pol_q;
  assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rise = scl_s & ~scl_p_q;
  assign fall = ~scl_s & scl_p_q;

  // ****************************************
  // Register read and input snapshot
  // ****************************************
  function automatic logic [7:0] rd_byte(input logic [2:0] p, input logic [15:0] lv,
                                         input logic [15:0] o, input logic [15:0] n,
                                         input logic [15:0] c);
    logic [7:0] r;
    r = 8'h00;
    unique case (p)
      PTR_IN0: r = lv[7:0];
      PTR_IN1: r = lv[15:8];
      PTR_OUT0: r = o[7:0];
      PTR_OUT1: r = o[15:8];
      PTR_POL0: r = n[7:0];
      PTR_POL1: r = n[15:8];
      PTR_CFG0: r = c[7:0];
      PTR_CFG1: r = c[15:8];
    endcase
    return r;
  endfunction

  function automatic logic [15:0] in_snap(input logic [2:0] p, input logic [15:0] cur,
                                          input logic [15:0] lv);
    logic [15:0] r;
    r = cur;
    if (p == PTR_IN0) begin
      r[7:0] = lv[7:0];
    end else if (p == PTR_IN1) begin
      r[15:8] = lv[15:8];
    end
    return r;
  endfunction

  // ****************************************
  // Bus slave next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    after_d = after_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    nack_d = nack_q;
    out_d = out_q;
    pol_d = pol_q;
    cfg_d = cfg_q;
    in_d = in_q;
    if (start) begin
      st_d = ST_ADDR;
      cnt_d = BIT_CNT_RST;
    end else if (stop) begin
      st_d = ST_IDLE;
    end else if (rise) begin
      if (st_q inside {ST_ADDR, ST_CMD, ST_WDATA} && cnt_q != BYTE_BITS) begin
        sh_d = {sh_q[6:0], sda_s};
        cnt_d = cnt_q + 4'h1;
      end else if (st_q == ST_RACK) begin
        nack_d = sda_s;
      end
    end else if (fall) begin
      unique case (st_q)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (cnt_q == BYTE_BITS) begin
            if (sh_q[7:1] == {ADDR_HIGH, addr_s}) begin
              st_d = ST_ACK;
              rw_d = sh_q[0];
              after_d = sh_q[0] ? ST_RDATA : ST_CMD;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_CMD: begin
          if (cnt_q == BYTE_BITS) begin
            ptr_d = sh_q[2:0];
            st_d = ST_ACK;
            after_d = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (cnt_q == BYTE_BITS) begin
            unique case (ptr_q)
              PTR_IN0, PTR_IN1: begin
              end
              PTR_OUT0: out_d[7:0] = sh_q;
              PTR_OUT1: out_d[15:8] = sh_q;
              PTR_POL0: pol_d[7:0] = sh_q;
              PTR_POL1: pol_d[15:8] = sh_q;
              PTR_CFG0: cfg_d[7:0] = sh_q;
              PTR_CFG1: cfg_d[15:8] = sh_q;
            endcase
            ptr_d = {ptr_q[2:1], ~ptr_q[0]};
            st_d = ST_ACK;
            after_d = ST_WDATA;
          end
        end
        ST_ACK: begin
          cnt_d = BIT_CNT_RST;
          st_d = after_q;
          if (after_q == ST_RDATA) begin
            sh_d = rd_byte(ptr_q, live, out_q, pol_q, cfg_q);
            in_d = in_snap(ptr_q, in_q, live);
            ptr_d = {ptr_q[2:1], ~ptr_q[0]};
          end
        end
        ST_RDATA: begin
          if (cnt_q == LAST_RD_BIT) begin
            st_d = ST_RACK;
          end else begin
            sh_d = {sh_q[6:0], 1'b1};
            cnt_d = cnt_q + 4'h1;
          end
        end
        ST_RACK: begin
          if (nack_q) begin
            st_d = ST_IDLE;
          end else begin
            st_d = ST_RDATA;
            cnt_d = BIT_CNT_RST;
            sh_d = rd_byte(ptr_q, live, out_q, pol_q, cfg_q);
            in_d = in_snap(ptr_q, in_q, live);
            ptr_d = {ptr_q[2:1], ~ptr_q[0]};
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    oe_d = (st_d == ST_ACK) | ((st_d == ST_RDATA) & ~sh_d[7]);
    drv_d = ~cfg_d;
    int_d = |((live ^ in_q) & cfg_q);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= ST_IDLE;
      after_q <= ST_IDLE;
      sh_q <= 8'hff;
      cnt_q <= BIT_CNT_RST;
      ptr_q <= PTR_RST;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      out_q <= OUT_RST;
      pol_q <= POL_RST;
      cfg_q <= CFG_RST;
      in_q <= IN_RST;
      drv_q <= 16'h0000;
      oe_q <= 1'b0;
      int_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q <= st_d;
      after_q <= after_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      out_q <= out_d;
      pol_q <= pol_d;
      cfg_q <= cfg_d;
      in_q <= in_d;
      drv_q <= drv_d;
      oe_q <= oe_d;
      int_q <= int_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_q;
  assign PORT_A_OUT = out_q[7:0];
  assign PORT_B_OUT = out_q[15:8];
  assign PORT_A_OE = drv_q[7:0];
  assign PORT_B_OE = drv_q[15:8];
  assign PULLUP_EN = 1'b1;
  assign INT_N_OUT = 1'b0;
  assign INT_N_OE = int_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_int_follows;
    @(posedge CLK) disable iff (RESET)
      (|((live ^ in_q) & cfg_q)) |=> INT_N_OE;
  endproperty
  a_int_follows: assert property (p_int_follows) else $error("interrupt missed");
  property p_int_quiet;
    @(posedge CLK) disable iff (RESET)
      !(|((live ^ in_q) & cfg_q)) |=> !INT_N_OE;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("spurious interrupt");
  property p_reset_state;
    @(posedge CLK) RESET |=> st_q == ST_IDLE && ptr_q == PTR_RST && out_q == OUT_RST
      && pol_q == POL_RST && cfg_q == CFG_RST;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset defaults wrong");
  property p_addr_miss;
    @(posedge CLK) disable iff (RESET)
      (fall && !start && !stop && st_q == ST_ADDR && cnt_q == BYTE_BITS
       && sh_q[7:1] != {ADDR_HIGH, addr_s}) |=> st_q == ST_IDLE && !SDA_OE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("ack on wrong address");
  property p_addr_hit;
    @(posedge CLK) disable iff (RESET)
      (fall && !start && !stop && st_q == ST_ADDR && cnt_q == BYTE_BITS
       && sh_q[7:1] == {ADDR_HIGH, addr_s}) |=> SDA_OE && rw_q == $past(sh_q[0]);
  endproperty
  a_addr_hit: assert property (p_addr_hit) else $error("address not acked");
  property p_no_drive_reset;
    @(posedge CLK) $fell(RESET) |-> (PORT_A_OE == 8'h00 && PORT_B_OE == 8'h00) [*2];
  endproperty
  a_no_drive_reset: assert property (p_no_drive_reset) else $error("pin driven at reset");
  property p_out_write;
    @(posedge CLK) disable iff (RESET)
      (fall && !start && !stop && st_q == ST_WDATA && cnt_q == BYTE_BITS
       && ptr_q == PTR_OUT1) |=> PORT_B_OUT == $past(sh_q) ##1 PORT_B_OUT == $past(sh_q, 2);
  endproperty
  a_out_write: assert property (p_out_write) else $error("output write lost");
  property p_out_hold;
    @(posedge CLK) disable iff (RESET)
      st_q != ST_WDATA |=> $stable(out_q);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output changed unwritten");
  property p_dir_write;
    @(posedge CLK) disable iff (RESET)
      (fall && !start && !stop && st_q == ST_WDATA && cnt_q == BYTE_BITS
       && ptr_q == PTR_CFG0) |=> ##1 PORT_A_OE == ~$past(sh_q, 2);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not applied");
  property p_cmd_ptr;
    @(posedge CLK) disable iff (RESET)
      (fall && !start && !stop && st_q == ST_CMD && cnt_q == BYTE_BITS)
        |=> ptr_q == $past(sh_q[2:0]);
  endproperty
  a_cmd_ptr: assert property (p_cmd_ptr) else $error("pointer not loaded");
  property p_in_snap;
    @(posedge CLK) disable iff (RESET)
      (fall && !start && !stop && st_q == ST_ACK && after_q == ST_RDATA && ptr_q == PTR_IN0)
        |=> in_q[7:0] == ($past(pins_s[7:0]) ^ $past(pol_q[7:0]));
  endproperty
  a_in_snap: assert property (p_in_snap) else $error("input snapshot wrong");

  c_write: cover property (@(posedge CLK) st_q == ST_WDATA && fall && cnt_q == BYTE_BITS);
  c_read: cover property (@(posedge CLK) st_q == ST_RDATA ##[1:400] st_q == ST_RACK);
  c_nack: cover property (@(posedge CLK) st_q == ST_RACK && fall && nack_q);
  c_int: cover property (@(posedge CLK) $rose(INT_N_OE));
endmodule

/* verification/bus_master.sv */
// Behavioural I2C bus master for the expander bench
`timescale 1ns/1ps
module bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl_lo,
  output logic sda_lo,
  output logic res_v,
  output logic [7:0] res_d
);
  // ****************************************
  // Bit level, released lines float high
  // ****************************************
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    res_v = 1'b0;
    res_d = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_lo <= ~b;
    tick(8);
    scl_lo <= 1'b0;
    tick(10);
    r = sda;
    scl_lo <= 1'b1;
    tick(2);
  endtask
  task automatic start();
    sda_lo <= 1'b0;
    tick(8);
    scl_lo <= 1'b0;
    tick(10);
    sda_lo <= 1'b1;
    tick(10);
    scl_lo <= 1'b1;
    tick(2);
  endtask
  task automatic stop();
    sda_lo <= 1'b1;
    tick(8);
    scl_lo <= 1'b0;
    tick(10);
    sda_lo <= 1'b0;
    tick(10);
  endtask
  // ****************************************
  // Byte level, results reported one cycle
  // ****************************************
  task automatic emit(input logic [7:0] d);
    res_d <= d;
    res_v <= 1'b1;
    tick(1);
    res_v <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] d, input logic e);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    if (e) emit({7'h00, ~r});
  endtask
  task automatic rx(input logic last);
    logic r;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
    emit(d);
  endtask
endmodule

/* verification/tb.sv */
// Self-checking testbench of the I2C GPIO expander
`timescale 1ns/1ps
module tb import gpx_pkg::*;;
  logic CLK = 1'b0;
  logic RESET, m_scl_lo, m_sda_lo, res_v, snap_v, scl, sda, sda_oe, sda_out, pu_en;
  logic int_out, int_oe;
  logic [7:0] res_d, pa_in, pb_in, pa_out, pb_out, pa_oe, pb_oe;
  logic [15:0] ext, o, c, pol, exp_v, got_v;
  logic [2:0] strap;
  logic [1:0] snap_sel;
  logic [15:0] q_exp[$];
  string q_nm[$];
  string nm;
  string nms[3] = '{"port_oe", "port_out", "int_pins"};
  logic [15:0] dflt[3] = '{OUT_RST, POL_RST, CFG_RST};
  int err_count = 0;
  int compares = 0;
  int k;
  always #12.5 CLK = ~CLK;
  assign scl = ~m_scl_lo;
  assign sda = ~(m_sda_lo | (sda_oe & ~sda_out));
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext[7:0]);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext[15:8]);
  i2c_gpio_expander_16bit i_i2c_gpio_expander_16bit (
    .CLK(CLK), .RESET(RESET), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ADDR_SEL_BIT0(strap[0]), .ADDR_SEL_BIT1(strap[1]),
    .ADDR_SEL_BIT2(strap[2]), .PORT_A_IN(pa_in), .PORT_A_OUT(pa_out), .PORT_A_OE(pa_oe),
    .PORT_B_IN(pb_in), .PORT_B_OUT(pb_out), .PORT_B_OE(pb_oe), .PULLUP_EN(pu_en),
    .INT_N_OUT(int_out), .INT_N_OE(int_oe)
  );
  bus_master i_bus_master (
    .clk(CLK), .sda(sda), .scl_lo(m_scl_lo), .sda_lo(m_sda_lo), .res_v(res_v),
    .res_d(res_d)
  );
  // ****************************************
  // Result monitor
  // ****************************************
  function automatic logic [15:0] port_val(input logic [1:0] s);
    case (s)
      2'h0: return {pb_oe, pa_oe};
      2'h1: return {pb_out, pa_out};
      default: return {13'h0, pu_en, int_out, int_oe};
    endcase
  endfunction
  always @(posedge CLK) begin
    if (res_v || snap_v) begin
      exp_v = q_exp.pop_front();
      nm = q_nm.pop_front();
      got_v = res_v ? {8'h00, res_d} : port_val(snap_sel);
      compares++;
      if (got_v !== exp_v) begin
        err_count++;
        $display("Error %s expected %h seen %h", nm, exp_v, got_v);
      end
    end
  end
  // ****************************************
  // Driver tasks
  // ****************************************
  task automatic note(input string n, input logic [15:0] v);
    q_exp.push_back(v);
    q_nm.push_back(n);
  endtask
  task automatic snap(input logic [1:0] s, input logic [15:0] v);
    note(nms[s], v);
    snap_sel <= s;
    snap_v <= 1'b1;
    @(posedge CLK);
    snap_v <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic probe(input logic [6:0] a, input logic ack);
    note("addr_ack", {15'h0, ack});
    i_bus_master.start();
    i_bus_master.tx({a, 1'b0}, 1'b1);
    i_bus_master.stop();
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    note("addr_ack", 16'h0001);
    i_bus_master.start();
    i_bus_master.tx({ADDR_HIGH_DEF, strap, 1'b0}, 1'b1);
    i_bus_master.tx(cmd, 1'b0);
    i_bus_master.tx(d[7:0], 1'b0);
    i_bus_master.tx(d[15:8], 1'b0);
    i_bus_master.stop();
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] e);
    note("addr_ack", 16'h0001);
    note("addr_ack", 16'h0001);
    note("rd_lo", {8'h00, e[7:0]});
    note("rd_hi", {8'h00, e[15:8]});
    i_bus_master.start();
    i_bus_master.tx({ADDR_HIGH_DEF, strap, 1'b0}, 1'b1);
    i_bus_master.tx(cmd, 1'b0);
    i_bus_master.start();
    i_bus_master.tx({ADDR_HIGH_DEF, strap, 1'b1}, 1'b1);
    i_bus_master.rx(1'b0);
    i_bus_master.rx(1'b1);
    i_bus_master.stop();
  endtask
  task automatic summarize();
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (40000) @(posedge CLK);
    err_count++;
    summarize();
  end
  initial begin
    RESET = 1'b1;
    ext = 16'hffff;
    strap = 3'h0;
    snap_v = 1'b0;
    snap_sel = 2'h0;
    void'($urandom(4));
    repeat (5) @(posedge CLK);
    snap(2'h0, 16'h0000);
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    repeat (8) @(posedge CLK);
    snap(2'h0, 16'h0000);
    snap(2'h1, OUT_RST);
    snap(2'h2, 16'h0004);
    for (int i = 0; i < 3; i++) rd(8'(2 * i + 2), dflt[i]);
    rd(8'h00, 16'hffff);
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      repeat (8) @(posedge CLK);
      probe({ADDR_HIGH_DEF, 3'(s)}, 1'b1);
      probe({ADDR_HIGH_DEF, 3'(s + 1)}, 1'b0);
      probe({ADDR_HIGH_DEF ^ 4'h8, 3'(s)}, 1'b0);
    end
    strap <= 3'($urandom);
    ext <= 16'($urandom);
    repeat (8) @(posedge CLK);
    rd(8'h00, ext);
    snap(2'h2, 16'h0004);
    k = $urandom % 16;
    ext[k] <= ~ext[k];
    repeat (8) @(posedge CLK);
    snap(2'h2, 16'h0005);
    rd(8'h00, ext);
    snap(2'h2, 16'h0004);
    o = 16'($urandom);
    c = 16'($urandom);
    pol = 16'($urandom);
    wr(8'hfa, o);
    snap(2'h0, 16'h0000);
    wr(8'h06, c);
    snap(2'h0, ~c);
    snap(2'h1, o);
    wr(8'h04, pol);
    wr(8'h00, ~o);
    rd(8'h02, o);
    rd(8'h00, ((~c & o) | (c & ext)) ^ pol);
    snap(2'h1, o);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    snap(2'h0, 16'h0000);
    RESET <= 1'b0;
    repeat (8) @(posedge CLK);
    snap(2'h1, OUT_RST);
    rd(8'h06, CFG_RST);
    rd(8'h04, POL_RST);
    repeat (4) @(posedge CLK);
    err_count += q_exp.size();
    summarize();
  end
endmodule
